/* core/mio_pkg.sv */
package mio_pkg;
    // register byte addresses, control registers four bytes apart
    localparam logic [7:0] ADDR_PORT_A_OUT = 8'h00;
    localparam logic [7:0] ADDR_PORT_B_OUT = 8'h04;
    localparam logic [7:0] ADDR_PORT_C_OUT = 8'h08;
    localparam logic [7:0] ADDR_PORT_D_OUT = 8'h0C;
    localparam logic [7:0] ADDR_PORT_A_IN = 8'h10;
    localparam logic [7:0] ADDR_PORT_B_IN = 8'h14;
    localparam logic [7:0] ADDR_PORT_C_IN = 8'h18;
    localparam logic [7:0] ADDR_PORT_D_IN = 8'h1C;
    localparam logic [7:0] ADDR_TMR_MODE = 8'h20;
    localparam logic [7:0] ADDR_TMR_OUT = 8'h24;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h28;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h2C;
    localparam logic [7:0] ADDR_CPU_FLAG = 8'h30;
    localparam logic [7:0] ADDR_MEM_SIZE = 8'h34;
    localparam logic [7:0] ADDR_RAM_BASE = 8'h80;
    // status and mask bit positions
    localparam int STAT_OVF_BIT = 0;
    localparam int STAT_PA0_RISE_BIT = 1;
    localparam int STAT_PA1_FALL_BIT = 2;
    localparam int STAT_NMI_BIT = 3;
    localparam int STAT_WIDTH = 4;
    localparam int MASK_FLAG_BIT = 0;
    // reset values
    localparam logic [7:0] PORT_OUT_RST = 8'hFF;
    localparam logic [3:0] IRQ_MASK_RST = 4'h0;
    localparam logic [1:0] TMR_MODE_RST = 2'h0;
    // memory sizes
    localparam int ROM_BYTES = 2048;
    localparam int RAM_BYTES = 64;
    localparam int RAM_AW = 6;
    localparam int PORT_COUNT = 4;
    // initialization hold, in clock cycles of the device clock
    localparam int INIT_HOLD_CYCLES = 8;

    typedef enum logic [1:0] {
        TMR_INTERVAL = 2'b00,
        TMR_PULSE_GEN = 2'b01,
        TMR_EVENT_CNT = 2'b10,
        TMR_PULSE_WIDTH = 2'b11
    } mio_tmr_mode_type;
endpackage

/* core/mio_ram.sv */
`timescale 1ns/10ps
module mio_ram (
    input wire logic core_clk,
    input wire logic wr_en,
    input wire logic [5:0] addr,
    input wire logic [7:0] wr_data,
    output logic [7:0] rd_data
);
    logic [7:0] mem [0:63];

    always_ff @(posedge core_clk) begin
        if (wr_en) begin
            mem[addr] <= wr_data;
        end
        rd_data <= mem[addr];
    end
endmodule

/* core/mio_top.sv */
// Local design decisions: the plain strobed port and the register offsets.
`timescale 1ns/10ps
// Functional notes
// R1 - the outside world holds chip_init_input low for eight cycles or more.
// R2 - a falling edge on the unmaskable interrupt pin raises an nmi request.
// R3 - four 8-bit ports give 32 lines, each usable as input or output.
// R4 - port lines only pull low; a high comes from the external pull-up.
// R5 - the two low lines of port a detect edges with maskable interrupts.
// R6 - the timer pin is an input in event count and pulse width modes.
// R7 - the timer pin pulls low as an output in interval and pulse modes.
// R8 - the chip holds 2048 bytes of rom and 64 bytes of ram.
// R9 - irq comes from counter overflow, pa0 rise or pa1 fall; irq_out also follows the nmi flag when mask bit 3 is set.
// R10 - a pending irq is taken only while the mask flag is clear.
// R11 - init or an nmi sets the interrupt mask flag to one.
// R12 - edge inputs are synchronised and their flags held until cleared.
module mio_top
    import mio_pkg::*;
(
    input wire logic core_clk,
    input wire logic srst,
    input wire logic chip_init_input_n,
    input wire logic nmi_input_n,
    input wire logic [7:0] port_a_lines_in,
    output logic [7:0] port_a_lines_out,
    output logic [7:0] port_a_lines_oe,
    input wire logic [7:0] port_b_lines_in,
    output logic [7:0] port_b_lines_out,
    output logic [7:0] port_b_lines_oe,
    input wire logic [7:0] port_c_lines_in,
    output logic [7:0] port_c_lines_out,
    output logic [7:0] port_c_lines_oe,
    input wire logic [7:0] port_d_lines_in,
    output logic [7:0] port_d_lines_out,
    output logic [7:0] port_d_lines_oe,
    input wire logic timer_io_pin_in,
    output logic timer_io_pin_out,
    output logic timer_io_pin_oe,
    input wire logic counter_ovf,
    input wire logic cpu_irq_ack,
    output logic cpu_nmi_req,
    output logic cpu_irq_req,
    output logic irq_out,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata
);
    import mio_pkg::*;

    // ************************************************************
    // pin synchronisers
    // ************************************************************
    localparam int SYNC_W = 32 + 3;
    logic [SYNC_W-1:0] sync1_r;
    logic [SYNC_W-1:0] sync2_r;
    logic [SYNC_W-1:0] raw_in;
    logic [SYNC_W-1:0] prev_r;

    assign raw_in = {timer_io_pin_in, nmi_input_n, chip_init_input_n,
                     port_d_lines_in, port_c_lines_in,
                     port_b_lines_in, port_a_lines_in};

    // first stage read only by second stage [R12]
    always_ff @(posedge core_clk) begin
        if (srst) begin
            sync1_r <= '1;
            sync2_r <= '1;
        end else begin
            sync1_r <= raw_in;
            sync2_r <= sync1_r;
        end
    end

    // history for the edge detectors; resets to the pulled-up idle
    // level so that no false edge follows reset [R12]
    always_ff @(posedge core_clk) begin
        if (srst) begin
            prev_r <= '1;
        end else begin
            prev_r <= sync2_r;
        end
    end

    logic [7:0] pin_in [0:PORT_COUNT-1];
    logic init_s;
    logic nmi_s;
    logic nmi_prev;
    logic tmr_s;
    assign init_s = sync2_r[32];
    assign nmi_s = sync2_r[33];
    assign nmi_prev = prev_r[33];
    assign tmr_s = sync2_r[34];

    // ************************************************************
    // init hold: the low time is the far side's duty, counted here
    // ************************************************************
    logic [3:0] init_cnt_r;
    logic init_active_r;

    // internal init stays asserted until the pin has been low long
    // enough and then released [R1]
    always_ff @(posedge core_clk) begin
        if (srst) begin
            init_cnt_r <= 4'h0;
            init_active_r <= 1'b1;
        end else if (!init_s) begin
            init_active_r <= 1'b1;
            if (init_cnt_r != 4'(INIT_HOLD_CYCLES)) begin
                init_cnt_r <= init_cnt_r + 4'h1;
            end
        end else begin
            if (init_cnt_r == 4'(INIT_HOLD_CYCLES)) begin
                init_active_r <= 1'b0;
            end
            init_cnt_r <= 4'h0;
        end
    end

    // ************************************************************
    // ports
    // ************************************************************
    logic [7:0] port_out_r [0:PORT_COUNT-1];
    logic [7:0] pin_out [0:PORT_COUNT-1];
    logic [7:0] pin_oe [0:PORT_COUNT-1];

    genvar gp;
    generate
        for (gp = 0; gp < PORT_COUNT; gp++) begin : g_port
            logic [7:0] wr_addr;
            assign wr_addr = ADDR_PORT_A_OUT + 8'(gp * 4);
            assign pin_in[gp] = sync2_r[gp*8 +: 8];
            // writing one releases the line so it can serve as input [R3]
            always_ff @(posedge core_clk) begin
                if (srst || init_active_r) begin
                    port_out_r[gp] <= PORT_OUT_RST;
                end else if (reg_wr && reg_addr == wr_addr) begin
                    port_out_r[gp] <= reg_wdata;
                end
            end
            // drive only the low level, pull-up gives the high [R4]
            assign pin_out[gp] = 8'h00;
            assign pin_oe[gp] = ~port_out_r[gp];
        end
    endgenerate

    assign port_a_lines_out = pin_out[0];
    assign port_b_lines_out = pin_out[1];
    assign port_c_lines_out = pin_out[2];
    assign port_d_lines_out = pin_out[3];
    assign port_a_lines_oe = pin_oe[0];
    assign port_b_lines_oe = pin_oe[1];
    assign port_c_lines_oe = pin_oe[2];
    assign port_d_lines_oe = pin_oe[3];

    // ************************************************************
    // timer pin
    // ************************************************************
    mio_tmr_mode_type tmr_mode_r;
    logic tmr_out_r;
    logic tmr_drives;

    logic wr_tmr_mode;
    logic wr_tmr_out;

    assign wr_tmr_mode = reg_wr && reg_addr == ADDR_TMR_MODE;
    assign wr_tmr_out = reg_wr && reg_addr == ADDR_TMR_OUT;

    always_ff @(posedge core_clk) begin
        if (srst || init_active_r) begin
            tmr_mode_r <= mio_tmr_mode_type'(TMR_MODE_RST);
        end else if (wr_tmr_mode) begin
            tmr_mode_r <= mio_tmr_mode_type'(reg_wdata[1:0]);
        end
    end

    // released (one) after init so the pin floats until software
    // asks for a low level
    always_ff @(posedge core_clk) begin
        if (srst || init_active_r) begin
            tmr_out_r <= 1'b1;
        end else if (wr_tmr_out) begin
            tmr_out_r <= reg_wdata[0];
        end
    end

    always_comb begin
        case (tmr_mode_r)
            TMR_INTERVAL: tmr_drives = 1'b1; // [R7]
            TMR_PULSE_GEN: tmr_drives = 1'b1; // [R7]
            TMR_EVENT_CNT: tmr_drives = 1'b0; // [R6]
            TMR_PULSE_WIDTH: tmr_drives = 1'b0; // [R6]
            default: tmr_drives = 1'b0;
        endcase
    end

    assign timer_io_pin_out = 1'b0;
    assign timer_io_pin_oe = tmr_drives & ~tmr_out_r; // [R7]

    // ************************************************************
    // interrupt events
    // ************************************************************
    logic [STAT_WIDTH-1:0] irq_stat_r;
    logic [STAT_WIDTH-1:0] irq_mask_r;
    logic [STAT_WIDTH-1:0] ev;
    logic [STAT_WIDTH-1:0] clr;
    logic mask_flag_r;

    assign ev[STAT_OVF_BIT] = counter_ovf; // [R9]
    assign ev[STAT_PA0_RISE_BIT] = sync2_r[0] & ~prev_r[0]; // [R5] [R9]
    assign ev[STAT_PA1_FALL_BIT] = ~sync2_r[1] & prev_r[1]; // [R5] [R9]
    assign ev[STAT_NMI_BIT] = ~nmi_s & nmi_prev; // [R2]
    assign clr = (reg_wr && reg_addr == ADDR_IRQ_STAT) ?
                 reg_wdata[STAT_WIDTH-1:0] : '0;

    // set wins over clear, flags held until cleared [R12]
    always_ff @(posedge core_clk) begin
        if (srst || init_active_r) begin
            irq_stat_r <= '0;
        end else begin
            irq_stat_r <= (irq_stat_r & ~clr) | ev;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst || init_active_r) begin
            irq_mask_r <= IRQ_MASK_RST;
        end else if (reg_wr && reg_addr == ADDR_IRQ_MASK) begin
            irq_mask_r <= reg_wdata[STAT_WIDTH-1:0];
        end
    end

    // the flag is forced on by init, by a detected nmi and by cpu_irq_ack [R11]
    always_ff @(posedge core_clk) begin
        if (srst || init_active_r) begin
            mask_flag_r <= 1'b1;
        end else if (ev[STAT_NMI_BIT] || cpu_irq_ack) begin
            mask_flag_r <= 1'b1;
        end else if (reg_wr && reg_addr == ADDR_CPU_FLAG) begin
            mask_flag_r <= reg_wdata[MASK_FLAG_BIT];
        end
    end

    logic [2:0] irq_src;
    assign irq_src = irq_stat_r[2:0] & irq_mask_r[2:0];
    assign cpu_irq_req = (|irq_src) & ~mask_flag_r; // [R9] [R10]
    assign cpu_nmi_req = irq_stat_r[STAT_NMI_BIT]; // [R2]
    assign irq_out = |(irq_stat_r & irq_mask_r);

    // ************************************************************
    // data memory and read port
    // ************************************************************
    logic ram_sel;
    logic [7:0] ram_rdata;
    logic ram_rd_r;
    logic [7:0] rd_r;

    assign ram_sel = reg_addr >= ADDR_RAM_BASE &&
                     reg_addr < ADDR_RAM_BASE + 8'(RAM_BYTES);

    // 64-byte data memory, one-cycle read [R8]
    mio_ram u_ram (
        .core_clk(core_clk),
        .wr_en(reg_wr && ram_sel),
        .addr(reg_addr[RAM_AW-1:0]),
        .wr_data(reg_wdata),
        .rd_data(ram_rdata)
    );

    // the memory's read register is picked for exactly one cycle,
    // so a later read of a control register is not shadowed
    always_ff @(posedge core_clk) begin
        if (srst) begin
            ram_rd_r <= 1'b0;
        end else begin
            ram_rd_r <= reg_rd && ram_sel;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            rd_r <= 8'h00;
        end else begin
            rd_r <= 8'h00;
            if (reg_rd) begin
                case (reg_addr)
                    ADDR_PORT_A_OUT: rd_r <= port_out_r[0];
                    ADDR_PORT_B_OUT: rd_r <= port_out_r[1];
                    ADDR_PORT_C_OUT: rd_r <= port_out_r[2];
                    ADDR_PORT_D_OUT: rd_r <= port_out_r[3];
                    ADDR_PORT_A_IN: rd_r <= pin_in[0];
                    ADDR_PORT_B_IN: rd_r <= pin_in[1];
                    ADDR_PORT_C_IN: rd_r <= pin_in[2];
                    ADDR_PORT_D_IN: rd_r <= pin_in[3];
                    ADDR_TMR_MODE: rd_r <= {6'h00, tmr_mode_r};
                    ADDR_TMR_OUT: rd_r <= {6'h00, tmr_s, tmr_out_r};
                    ADDR_IRQ_STAT: rd_r <= {4'h0, irq_stat_r};
                    ADDR_IRQ_MASK: rd_r <= {4'h0, irq_mask_r};
                    ADDR_CPU_FLAG: rd_r <= {7'h00, mask_flag_r};
                    // rom size in kbytes, ram size in bytes/16 [R8]
                    ADDR_MEM_SIZE: rd_r <= {4'(ROM_BYTES / 1024),
                                            4'(RAM_BYTES / 16)};
                    default: rd_r <= 8'h00;
                endcase
            end
        end
    end

    assign reg_rdata = ram_rd_r ? ram_rdata : rd_r;
endmodule

/* tb/mio_periph.sv */
`timescale 1ns/10ps
// ****************************************
// peripheral circuitry on the pins
// ****************************************
module mio_periph (
    input wire logic [31:0] dev_oe,
    input wire logic [31:0] ext_low,
    input wire logic tmr_oe,
    output logic [31:0] line_lvl,
    output logic tmr_lvl
);
    // pull-ups fitted: a line nobody pulls down reads high
    assign line_lvl = ~(dev_oe | ext_low);
    assign tmr_lvl = ~tmr_oe;
endmodule

/* tb/mio_top_sva.sv */
`timescale 1ns/10ps
// ****************************************
// port-level checker
// ****************************************
module mio_top_sva
    import mio_pkg::*;
(
    input wire logic core_clk, input wire logic srst,
    input wire logic nmi_input_n, input wire logic [7:0] port_a_lines_in,
    input wire logic [7:0] port_a_lines_out,
    input wire logic [7:0] port_b_lines_out,
    input wire logic [7:0] port_c_lines_out,
    input wire logic [7:0] port_d_lines_out,
    input wire logic timer_io_pin_out,
    input wire logic [7:0] port_a_lines_oe, input wire logic counter_ovf,
    input wire logic cpu_irq_ack, input wire logic cpu_nmi_req,
    input wire logic cpu_irq_req, input wire logic irq_out,
    input wire logic [7:0] reg_addr, input wire logic [7:0] reg_wdata,
    input wire logic reg_wr, input wire logic reg_rd,
    input wire logic [7:0] reg_rdata
);
    // shadow of the mask, the bench never writes it during init
    logic [3:0] mask_r;
    always_ff @(posedge core_clk) begin
        if (srst) begin
            mask_r <= IRQ_MASK_RST;
        end else if (reg_wr && reg_addr == ADDR_IRQ_MASK) begin
            mask_r <= reg_wdata[3:0];
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);
    drain_only_a: assert property (
        (port_a_lines_out | port_b_lines_out | port_c_lines_out
         | port_d_lines_out) == 8'h00 && !timer_io_pin_out)
        else $error("drive high");
    nmi_req_a: assert property (
        $fell(nmi_input_n) |-> ##[3:4] cpu_nmi_req) else $error("nmi lost");
    pa0_rise_a: assert property (
        $rose(port_a_lines_in[0]) && mask_r[1] |-> ##[3:4] irq_out)
        else $error("pa0 edge lost");
    pa1_fall_a: assert property (
        $fell(port_a_lines_in[1]) && mask_r[2] |-> ##[3:4] irq_out)
        else $error("pa1 edge lost");
    ovf_irq_a: assert property (
        counter_ovf && mask_r[0] |=> irq_out) else $error("ovf lost");
    masked_quiet_a: assert property (
        irq_out |-> mask_r != 4'h0) else $error("masked irq");
    irq_gate_a: assert property (
        cpu_irq_req |-> irq_out) else $error("irq without source");
    ack_block_a: assert property (
        cpu_irq_ack |=> !cpu_irq_req) else $error("irq after ack");
    port_oe_a: assert property (
        reg_wr && reg_addr == ADDR_PORT_A_OUT
        |=> port_a_lines_oe == ~$past(reg_wdata)) else $error("oe wrong");
    mem_size_a: assert property (
        reg_rd && reg_addr == ADDR_MEM_SIZE |=> reg_rdata == 8'h24)
        else $error("size wrong");
    cover property (counter_ovf && mask_r[0]);
    cover property ($fell(nmi_input_n));
    cover property (cpu_irq_ack && cpu_irq_req);
    cover property ($rose(port_a_lines_in[0]) && mask_r[1]);
endmodule

bind mio_top mio_top_sva u_sva (
    .core_clk(core_clk), .srst(srst), .nmi_input_n(nmi_input_n),
    .port_a_lines_in(port_a_lines_in), .port_a_lines_out(port_a_lines_out),
    .port_b_lines_out(port_b_lines_out),
    .port_c_lines_out(port_c_lines_out),
    .port_d_lines_out(port_d_lines_out), .port_a_lines_oe(port_a_lines_oe),
    .timer_io_pin_out(timer_io_pin_out),
    .counter_ovf(counter_ovf), .cpu_irq_ack(cpu_irq_ack),
    .cpu_nmi_req(cpu_nmi_req), .cpu_irq_req(cpu_irq_req), .irq_out(irq_out),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata)
);

/* tb/mio_top_tb.sv */
`timescale 1ns/10ps
// ****************************************
// bench
// ****************************************
module mio_top_tb;
    import mio_pkg::*;
    logic core_clk = 0, srst = 1, init_n = 0, nmi_n = 1, ovf = 0, ack = 0;
    logic wr = 0, rd = 0, t_oe, t_lvl, nmi_req, irq_req, irq;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
    logic [31:0] ext_low = 32'h0;
    wire [31:0] oe, lvl;
    int mismatches = 0, num_checks = 0, cycles = 0;
    always #50 core_clk = ~core_clk;
    mio_top dut (.core_clk(core_clk), .srst(srst), .chip_init_input_n(init_n),
        .nmi_input_n(nmi_n), .port_a_lines_in(lvl[7:0]),
        .port_a_lines_out(), .port_a_lines_oe(oe[7:0]),
        .port_b_lines_in(lvl[15:8]), .port_b_lines_out(),
        .port_b_lines_oe(oe[15:8]), .port_c_lines_in(lvl[23:16]),
        .port_c_lines_out(), .port_c_lines_oe(oe[23:16]),
        .port_d_lines_in(lvl[31:24]), .port_d_lines_out(),
        .port_d_lines_oe(oe[31:24]), .timer_io_pin_in(t_lvl),
        .timer_io_pin_out(), .timer_io_pin_oe(t_oe), .counter_ovf(ovf),
        .cpu_irq_ack(ack), .cpu_nmi_req(nmi_req), .cpu_irq_req(irq_req),
        .irq_out(irq), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr),
        .reg_rd(rd), .reg_rdata(rdata));
    mio_periph periph (.dev_oe(oe), .ext_low(ext_low), .tmr_oe(t_oe),
        .line_lvl(lvl), .tmr_lvl(t_lvl));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %0t got %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic wr8(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        wr <= 1;
        addr <= a;
        wdata <= d;
        @(posedge core_clk);
        wr <= 0;
        #1;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        rd <= 1;
        addr <= a;
        @(posedge core_clk);
        rd <= 0;
        #1;
        check(rdata, exp);
    endtask
    task automatic pulse(input int sel);
        @(posedge core_clk);
        if (sel == 0) ovf <= 1; else ack <= 1;
        @(posedge core_clk);
        ovf <= 0;
        ack <= 0;
        #1;
    endtask
    task automatic tug(input int b);
        @(posedge core_clk);
        ext_low[b] <= 1'b1;
        idle(5);
        ext_low[b] <= 1'b0;
        idle(5);
    endtask
    task automatic test_mem;
        rdc(ADDR_CPU_FLAG, 8'h01);
        check(oe[7:0], 8'h00);
        rdc(ADDR_MEM_SIZE, 8'h24);
        wr8(ADDR_RAM_BASE, 8'hA5);
        wr8(ADDR_RAM_BASE + 8'h3F, 8'h5A);
        rdc(ADDR_RAM_BASE, 8'hA5);
        rdc(ADDR_RAM_BASE + 8'h3F, 8'h5A);
        wr8(8'h40, 8'hFF);
        rdc(8'h40, 8'h00);
        $display("test_mem done");
    endtask
    task automatic test_ports;
        logic [7:0] v;
        for (int i = 0; i < 4; i++) begin
            v = 8'h3C ^ 8'(i);
            wr8(ADDR_PORT_A_OUT + 8'(4 * i), v);
            check(oe[8*i +: 8], ~v);
            rdc(ADDR_PORT_A_OUT + 8'(4 * i), v);
            ext_low[8*i +: 8] <= 8'h81;
            idle(4);
            rdc(ADDR_PORT_A_IN + 8'(4 * i), v & 8'h7E);
            ext_low <= 32'h0;
            wr8(ADDR_PORT_A_OUT + 8'(4 * i), PORT_OUT_RST);
        end
        $display("test_ports done");
    endtask
    task automatic test_timer;
        for (int m = 0; m < 4; m++) begin
            wr8(ADDR_TMR_MODE, 8'(m));
            wr8(ADDR_TMR_OUT, 8'h00);
            check({7'h0, t_oe}, (m < 2) ? 8'h01 : 8'h00);
            idle(3);
            rdc(ADDR_TMR_OUT, (m < 2) ? 8'h00 : 8'h02);
            rdc(ADDR_TMR_MODE, 8'(m));
        end
        wr8(ADDR_TMR_OUT, 8'h01);
        $display("test_timer done");
    endtask
    task automatic test_irq;
        wr8(ADDR_IRQ_STAT, 8'h0F);
        tug(1);
        check({7'h0, irq}, 8'h00);
        rdc(ADDR_IRQ_STAT, 8'h04);
        wr8(ADDR_IRQ_MASK, 8'h04);
        check({7'h0, irq}, 8'h01);
        wr8(ADDR_IRQ_STAT, 8'h04);
        check({7'h0, irq}, 8'h00);
        wr8(ADDR_IRQ_MASK, 8'h06);
        tug(0);
        tug(1);
        rdc(ADDR_IRQ_STAT, 8'h06);
        wr8(ADDR_IRQ_STAT, 8'h06);
        wr8(ADDR_IRQ_MASK, 8'h07);
        rdc(ADDR_IRQ_MASK, 8'h07);
        wr8(ADDR_CPU_FLAG, 8'h00);
        pulse(0);
        check({6'h0, irq_req, irq}, 8'h03);
        pulse(1);
        check({7'h0, irq_req}, 8'h00);
        rdc(ADDR_CPU_FLAG, 8'h01);
        rdc(ADDR_IRQ_STAT, 8'h01);
        wr8(ADDR_IRQ_STAT, 8'h01);
        $display("test_irq done");
    endtask
    task automatic test_nmi;
        wr8(ADDR_CPU_FLAG, 8'h00);
        rdc(ADDR_CPU_FLAG, 8'h00);
        nmi_n <= 0;
        idle(5);
        check({7'h0, nmi_req}, 8'h01);
        rdc(ADDR_CPU_FLAG, 8'h01);
        nmi_n <= 1;
        wr8(ADDR_IRQ_STAT, 8'h08);
        check({7'h0, nmi_req}, 8'h00);
        $display("test_nmi done");
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            finish_test;
        end
    end
    initial begin
        idle(4);
        srst <= 0;
        idle(10);
        init_n <= 1; // held low over eight cycles first
        idle(6);
        test_mem;
        test_ports;
        test_timer;
        test_irq;
        test_nmi;
        finish_test;
    end
endmodule
